// ==== ipr_regs.sv ====
// Interrupt priority register bank with AHB-Lite slave
//
// Chosen here: the address map and the AHB-Lite register port.
`default_nettype none
`include "ipr_defines.svh"
module ipr_regs #(
  parameter int NSRC = `IPR_NUM_SRCS
) (
  input  wire logic                sys_clk,     // System clock, 20 MHz
  input  wire logic                srst,        // Sync reset, high
  input  wire logic                hsel,        // Slave select
  input  wire logic [1:0]          htrans,      // Transfer type
  input  wire logic                hwrite,      // Write when high
  input  wire logic [2:0]          hsize,       // Word only
  input  wire logic [11:0]         haddr,       // Byte address
  input  wire logic [31:0]         hwdata,      // Write data
  input  wire logic                hready,      // Bus ready
  output logic                     hreadyout,   // Always ready
  output logic                     hresp,       // Always OKAY
  output logic      [31:0]         hrdata,      // Read data
  input  wire logic [NSRC-1:0]     srcReq,      // Peripheral requests
  output logic      [3*NSRC-1:0]   prioLvl,     // Level per source
  output logic      [NSRC-1:0]     srcEn,       // Source enabled
  output logic      [NSRC-1:0]     reqOut       // Enabled requests
);

  ipr_pkg::ipr_addr_phase_t curPhase;
  ipr_pkg::ipr_addr_phase_t pendWr;

  ipr_pkg::ipr_reg_t regs_ff [`IPR_NUM_REGS];
  ipr_pkg::ipr_reg_t nxt_regs [`IPR_NUM_REGS];
  logic [31:0]       hrdata_ff;
  logic [31:0]       nxt_hrdata;
  logic              hreadyout_ff;
  logic              nxt_hreadyout;
  logic              hresp_ff;
  logic              nxt_hresp;
  logic [3*NSRC-1:0] fields;

  // Implemented-bit mask per register index
  function automatic ipr_pkg::ipr_reg_t maskOf(input logic [2:0] idx);
    case (idx)
      3'h0:    maskOf = `IPR_MASK_CRC_UART_ERR;
      3'h1:    maskOf = `IPR_MASK_LOW_VOLTAGE;
      3'h2:    maskOf = `IPR_MASK_CHARGE_TIME;
      3'h3:    maskOf = `IPR_MASK_SERIAL3;
      3'h4:    maskOf = `IPR_MASK_SERIAL4_I2C;
      3'h5:    maskOf = `IPR_MASK_SPI3_SERIAL4;
      default: maskOf = 16'h0000;
    endcase
  endfunction

  // Reset value per register index
  function automatic ipr_pkg::ipr_reg_t rstOf(input logic [2:0] idx);
    case (idx)
      3'h0:    rstOf = `IPR_RST_CRC_UART_ERR;
      3'h1:    rstOf = `IPR_RST_LOW_VOLTAGE;
      3'h2:    rstOf = `IPR_RST_CHARGE_TIME;
      3'h3:    rstOf = `IPR_RST_SERIAL3;
      3'h4:    rstOf = `IPR_RST_SERIAL4_I2C;
      3'h5:    rstOf = `IPR_RST_SPI3_SERIAL4;
      default: rstOf = 16'h0000;
    endcase
  endfunction

  // Pull one 3-bit field out of a register
  function automatic ipr_pkg::ipr_prio_t fieldAt(input ipr_pkg::ipr_reg_t r, input int pos);
    fieldAt = r[pos +: 3];
  endfunction

  // Address phase capture
  ipr_ahb_front u_front (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .hsel      (hsel),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .haddr     (haddr),
    .hready    (hready),
    .curPhase  (curPhase),
    .pendWr_ff (pendWr)
  );

  // Register writes in the data phase; read data from the updated view
  always_comb
  begin
    for (int r = 0; r < `IPR_NUM_REGS; r++)
      nxt_regs[r] = regs_ff[r];
    if (pendWr.valid && pendWr.mapped)
      nxt_regs[pendWr.idx] = hwdata[15:0] & maskOf(pendWr.idx);
    nxt_hrdata = 32'h0000_0000;
    if (curPhase.valid && !curPhase.write && curPhase.mapped)
      nxt_hrdata = {16'h0000, nxt_regs[curPhase.idx] & maskOf(curPhase.idx)};
    nxt_hreadyout = 1'b1;
    nxt_hresp     = 1'b0;
  end

  // Bank storage and bus outputs
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int r = 0; r < `IPR_NUM_REGS; r++)
        regs_ff[r] <= rstOf(3'(r));
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      for (int r = 0; r < `IPR_NUM_REGS; r++)
        regs_ff[r] <= nxt_regs[r];
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
      hresp_ff     <= nxt_hresp;
    end
  end

  // Gather fields in source order 0..14
  always_comb
  begin
    fields = '0;
    fields[3*0  +: 3] = fieldAt(regs_ff[0], `IPR_POS_HI);
    fields[3*1  +: 3] = fieldAt(regs_ff[0], `IPR_POS_MIDHI);
    fields[3*2  +: 3] = fieldAt(regs_ff[0], `IPR_POS_MIDLO);
    fields[3*3  +: 3] = fieldAt(regs_ff[1], `IPR_POS_LO);
    fields[3*4  +: 3] = fieldAt(regs_ff[2], `IPR_POS_MIDLO);
    fields[3*5  +: 3] = fieldAt(regs_ff[3], `IPR_POS_HI);
    fields[3*6  +: 3] = fieldAt(regs_ff[3], `IPR_POS_MIDHI);
    fields[3*7  +: 3] = fieldAt(regs_ff[3], `IPR_POS_MIDLO);
    fields[3*8  +: 3] = fieldAt(regs_ff[4], `IPR_POS_HI);
    fields[3*9  +: 3] = fieldAt(regs_ff[4], `IPR_POS_MIDLO);
    fields[3*10 +: 3] = fieldAt(regs_ff[4], `IPR_POS_LO);
    fields[3*11 +: 3] = fieldAt(regs_ff[5], `IPR_POS_HI);
    fields[3*12 +: 3] = fieldAt(regs_ff[5], `IPR_POS_MIDHI);
    fields[3*13 +: 3] = fieldAt(regs_ff[5], `IPR_POS_MIDLO);
    fields[3*14 +: 3] = fieldAt(regs_ff[5], `IPR_POS_LO);
  end

  // Levels, enables and gated requests
  ipr_prio_decode #(
    .NSRC (NSRC)
  ) u_decode (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .fields     (fields),
    .srcReq     (srcReq),
    .prioLvl_ff (prioLvl),
    .srcEn_ff   (srcEn),
    .reqOut_ff  (reqOut)
  );

  // Bus outputs straight from flops
  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

endmodule // ipr_regs
`default_nettype wire

// ==== ipr_defines.svh ====
// Offsets, field positions, masks and reset values of the interrupt priority bank
`ifndef IPR_DEFINES_SVH
`define IPR_DEFINES_SVH

// Byte offsets of the six priority registers
`define IPR_OFF_CRC_UART_ERR   12'h000
`define IPR_OFF_LOW_VOLTAGE    12'h004
`define IPR_OFF_CHARGE_TIME    12'h008
`define IPR_OFF_SERIAL3        12'h00c
`define IPR_OFF_SERIAL4_I2C    12'h010
`define IPR_OFF_SPI3_SERIAL4   12'h014
`define IPR_NUM_REGS           6
`define IPR_NUM_SRCS           15

// Field low-bit positions within a 16-bit register
`define IPR_POS_HI             12
`define IPR_POS_MIDHI          8
`define IPR_POS_MIDLO          4
`define IPR_POS_LO             0

// Implemented-bit masks
`define IPR_MASK_CRC_UART_ERR  16'h7770
`define IPR_MASK_LOW_VOLTAGE   16'h0007
`define IPR_MASK_CHARGE_TIME   16'h0070
`define IPR_MASK_SERIAL3       16'h7770
`define IPR_MASK_SERIAL4_I2C   16'h7077
`define IPR_MASK_SPI3_SERIAL4  16'h7777

// Reset values: every implemented field holds 100
`define IPR_RST_CRC_UART_ERR   16'h4440
`define IPR_RST_LOW_VOLTAGE    16'h0004
`define IPR_RST_CHARGE_TIME    16'h0040
`define IPR_RST_SERIAL3        16'h4440
`define IPR_RST_SERIAL4_I2C    16'h4044
`define IPR_RST_SPI3_SERIAL4   16'h4444

// Field codes
`define IPR_CODE_DISABLED      3'h0

`endif

// ==== ipr_pkg.sv ====
// Types shared by the interrupt priority bank
`default_nettype none
package ipr_pkg;
  typedef logic [2:0]  ipr_prio_t;
  typedef logic [15:0] ipr_reg_t;

  // Captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] idx;
    logic       mapped;
  } ipr_addr_phase_t;
endpackage
`default_nettype wire

// ==== ipr_ahb_front.sv ====
// AHB-Lite address-phase capture and register index decode
`default_nettype none
`include "ipr_defines.svh"
module ipr_ahb_front (
  input  wire logic                    sys_clk,    // System clock
  input  wire logic                    srst,       // Sync reset, high
  input  wire logic                    hsel,       // Slave select
  input  wire logic [1:0]              htrans,     // Transfer type
  input  wire logic                    hwrite,     // Write when high
  input  wire logic [11:0]             haddr,      // Byte address
  input  wire logic                    hready,     // Bus ready
  output var  ipr_pkg::ipr_addr_phase_t curPhase,  // Decode of current address phase
  output var  ipr_pkg::ipr_addr_phase_t pendWr_ff  // Write awaiting its data phase
);

  ipr_pkg::ipr_addr_phase_t nxt_pendWr;

  // Map byte address onto register index
  function automatic logic [3:0] decodeAddr(input logic [11:0] a);
    case (a)
      `IPR_OFF_CRC_UART_ERR: decodeAddr = 4'h8;
      `IPR_OFF_LOW_VOLTAGE:  decodeAddr = 4'h9;
      `IPR_OFF_CHARGE_TIME:  decodeAddr = 4'ha;
      `IPR_OFF_SERIAL3:      decodeAddr = 4'hb;
      `IPR_OFF_SERIAL4_I2C:  decodeAddr = 4'hc;
      `IPR_OFF_SPI3_SERIAL4: decodeAddr = 4'hd;
      default:               decodeAddr = 4'h0;
    endcase
  endfunction

  // Current address phase and the next pending write
  always_comb
  begin
    logic [3:0] dec;
    dec              = decodeAddr(haddr);
    curPhase.valid   = hsel & htrans[1] & hready;
    curPhase.write   = hwrite;
    curPhase.idx     = dec[2:0];
    curPhase.mapped  = dec[3];
    nxt_pendWr       = curPhase;
    nxt_pendWr.valid = curPhase.valid & hwrite;
  end

  // Hold the write across into its data phase
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pendWr_ff <= '0;
    else
      pendWr_ff <= nxt_pendWr;
  end

endmodule // ipr_ahb_front
`default_nettype wire

// ==== ipr_prio_decode.sv ====
// Turns raw priority fields into levels, enables and gated requests
`default_nettype none
`include "ipr_defines.svh"
module ipr_prio_decode #(
  parameter int NSRC = `IPR_NUM_SRCS
) (
  input  wire logic                  sys_clk,     // System clock
  input  wire logic                  srst,        // Sync reset, high
  input  wire logic [3*NSRC-1:0]     fields,      // Raw 3-bit fields
  input  wire logic [NSRC-1:0]       srcReq,      // Source requests
  output logic      [3*NSRC-1:0]     prioLvl_ff,  // Level per source
  output logic      [NSRC-1:0]       srcEn_ff,    // Source enabled
  output logic      [NSRC-1:0]       reqOut_ff    // Requests passed on
);

  logic [3*NSRC-1:0] nxt_prioLvl;
  logic [NSRC-1:0]   nxt_srcEn;
  logic [NSRC-1:0]   nxt_reqOut;

  // Code 1..7 is the level itself; code 0 disables
  always_comb
  begin
    nxt_prioLvl = fields;
    for (int i = 0; i < NSRC; i++)
    begin
      nxt_srcEn[i]  = (fields[3*i +: 3] != `IPR_CODE_DISABLED);
      nxt_reqOut[i] = srcReq[i] & nxt_srcEn[i];
    end
  end

  // Register the decoded view; reset matches the level-4 default
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      prioLvl_ff <= {NSRC{3'h4}};
      srcEn_ff   <= '1;
      reqOut_ff  <= '0;
    end
    else
    begin
      prioLvl_ff <= nxt_prioLvl;
      srcEn_ff   <= nxt_srcEn;
      reqOut_ff  <= nxt_reqOut;
    end
  end

endmodule // ipr_prio_decode
`default_nettype wire

// ==== ipr_regs_properties.sv ====
// Checker of bus, reset and gating behaviour of the priority bank
`default_nettype none
module ipr_regs_properties #(
  parameter int NSRC = 15
) (
  input wire logic              sys_clk,   // Clock
  input wire logic              srst,      // Reset
  input wire logic              hsel,      // Select
  input wire logic [1:0]        htrans,    // Type
  input wire logic              hwrite,    // Write
  input wire logic [11:0]       haddr,     // Address
  input wire logic              hready,    // Ready in
  input wire logic              hreadyout, // Ready out
  input wire logic              hresp,     // Response
  input wire logic [31:0]       hrdata,    // Read data
  input wire logic [NSRC-1:0]   srcReq,    // Requests in
  input wire logic [3*NSRC-1:0] prioLvl,   // Levels
  input wire logic [NSRC-1:0]   srcEn,     // Enables
  input wire logic [NSRC-1:0]   reqOut     // Requests out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic            rd;
  logic            wr;
  logic [NSRC-1:0] lvlSet;
  // Accepted reads and writes
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign wr = hsel && htrans[1] && hready && hwrite;
  // Non-zero level per source
  always_comb
  begin
    for (int i = 0; i < NSRC; i++) lvlSet[i] = |prioLvl[3*i +: 3];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rdhi; rd |=> hrdata[31:16] == 16'h0; endproperty
  a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
  property p_unmap; rd && haddr >= 12'h018 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_lv; rd && haddr == 12'h004 |=> hrdata[15:3] == 13'h0; endproperty
  a_lv: assert property (p_lv) else $error("low voltage spare bits set");
  property p_ct; rd && haddr == 12'h008 |=> hrdata[15:7] == 9'h0 && hrdata[3:0] == 4'h0; endproperty
  a_ct: assert property (p_ct) else $error("charge time spare bits set");
  property p_s4; rd && haddr == 12'h010 |=> (hrdata[15:0] & 16'h8f88) == 16'h0; endproperty
  a_s4: assert property (p_s4) else $error("serial4 spare bits set");
  property p_rst; $past(srst) |-> prioLvl == {NSRC{3'h4}} && &srcEn && reqOut == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_en; srcEn == lvlSet; endproperty
  a_en: assert property (p_en) else $error("enable disagrees with level");
  property p_req; !$past(srst) |-> reqOut == ($past(srcReq) & srcEn); endproperty
  a_req: assert property (p_req) else $error("request gating wrong");
  property p_chg; $changed(prioLvl) |-> $past(wr, 3); endproperty
  a_chg: assert property (p_chg) else $error("level moved without write");
endmodule // ipr_regs_properties
bind ipr_regs ipr_regs_properties #(.NSRC(NSRC)) u_props (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .srcReq(srcReq), .prioLvl(prioLvl), .srcEn(srcEn), .reqOut(reqOut));
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench of the interrupt priority bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NSRC = 15;
  logic              sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0;
  logic [1:0]        htrans = 2'b00;
  logic [11:0]       haddr = 12'h000;
  logic [31:0]       hwdata = 32'h0, hrdata;
  logic              hreadyout, hresp;
  logic [NSRC-1:0]   srcReq = '0, srcEn, reqOut;
  logic [3*NSRC-1:0] prioLvl;
  logic [15:0]       q [$];
  logic [15:0]       mdl [6];
  logic [15:0]       msk [6] = '{16'h7770, 16'h0007, 16'h0070, 16'h7770, 16'h7077, 16'h7777};
  int                rg [15] = '{0, 0, 0, 1, 2, 3, 3, 3, 4, 4, 4, 5, 5, 5, 5};
  int                ps [15] = '{12, 8, 4, 0, 4, 12, 8, 4, 12, 4, 0, 12, 8, 4, 0};
  int                error_cnt = 0, tests_run = 0;
  ipr_regs #(.NSRC(NSRC)) u_dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .haddr(haddr), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .srcReq(srcReq), .prioLvl(prioLvl),
    .srcEn(srcEn), .reqOut(reqOut));
  // Clock, 50 ns period
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data against the oldest note
  always @(posedge sys_clk)
  begin
    if (rdPend)
    begin
      chk(hrdata, {48'h0, q.pop_front()});
      chk({hreadyout, hresp}, 2'b10);
    end
    rdPend <= !srst && hsel && htrans[1] && hreadyout && !hwrite;
  end
  // One single AHB transfer, noting what a read should return
  task automatic bus(input logic wr, input logic [11:0] adr, input logic [15:0] dat);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= adr;
    if (!wr)
      q.push_back(adr < 12'h018 ? mdl[adr[4:2]] : 16'h0);
    else if (adr < 12'h018)
      mdl[adr[4:2]] = dat & msk[adr[4:2]];
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'($urandom), dat};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic readall();
    for (int r = 0; r < 7; r++) bus(1'b0, 12'(4 * r), 16'h0);
  endtask
  // Levels, enables and gated requests per source
  task automatic lvlchk();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    for (int i = 0; i < NSRC; i++)
    begin
      chk(prioLvl[3*i +: 3], mdl[rg[i]][ps[i] +: 3]);
      chk(srcEn[i], |mdl[rg[i]][ps[i] +: 3]);
      chk(reqOut[i], srcReq[i] & |mdl[rg[i]][ps[i] +: 3]);
    end
    @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Reset, every code in every field, then a second reset
  initial
  begin
    void'($urandom(32'h5db2));
    for (int i = 0; i < 6; i++) mdl[i] = msk[i] & 16'h4444;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    readall();
    lvlchk();
    $display("reset test done");
    for (int k = 0; k < 12; k++)
    begin
      srcReq <= NSRC'($urandom);
      for (int r = 0; r < 7; r++)
        bus(1'b1, 12'(4 * r), k < 8 ? (16'($urandom) & 16'h8888) | 16'(16'h1111 * k) : 16'($urandom));
      readall();
      lvlchk();
    end
    $display("code test done");
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) mdl[i] = msk[i] & 16'h4444;
    readall();
    lvlchk();
    $display("second reset test done");
    report_and_stop();
  end
  // Watchdog
  initial
  begin
    #250us;
    error_cnt++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
